/* core/ddss_pkg.sv */
package ddss_pkg;

   // system and serial clock rates
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int SCLK_HZ    = 12_000_000;
   // half serial period in system cycles, rounded down so the rate stays at or above nominal
   localparam int SCLK_HALF_CYC = (SYS_CLK_HZ / (2 * SCLK_HZ)) < 1 ? 1
                                 : (SYS_CLK_HZ / (2 * SCLK_HZ));
   localparam int DIV_W = 8;

   // frame layout: control byte in the upper half, sample below it
   localparam int         FRAME_BITS = 16;
   localparam logic [3:0] LAST_BIT   = 4'hF;
   localparam logic [3:0] FIRST_BIT  = 4'h0;

   // register byte offsets
   localparam int          ADDR_W      = 12;
   localparam logic [11:0] CTRL_OFFS   = 12'h000;
   localparam logic [11:0] SAMPLE_OFFS = 12'h004;
   localparam logic [11:0] CMD_OFFS    = 12'h008;
   localparam logic [11:0] STAT_OFFS   = 12'h00C;

   // field positions
   localparam int START_BIT    = 0;
   localparam int WORD_A_LSB   = 0;
   localparam int WORD_B_LSB   = 8;
   localparam int STAT_DONE    = 0;
   localparam int STAT_STATE   = 1;

   // values after reset
   localparam logic [7:0] CTRL_BYTE_RST = 8'h00;
   localparam logic       FSYNC_RST     = 1'h1;
   localparam logic       DONE_RST      = 1'h1;
   localparam logic       START_RST     = 1'h0;
   localparam logic [7:0] WORD_RST      = 8'h00;

   // control states
   typedef enum logic [1:0] {
      IDLE       = 2'b00,
      SHIFTING   = 2'b01,
      SYNC_LATCH = 2'b10
   } ddss_state_type;

   // ahb-lite request side
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } ddss_ahb_in_type;

   // ahb-lite answer side
   typedef struct packed {
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        hresp;
   } ddss_ahb_out_type;

   // lines towards the converter module
   typedef struct packed {
      logic sclk;
      logic data_a;
      logic data_b;
      logic frame_sync_n;
   } ddss_dac_link_type;

endpackage

/* core/ddss_dac_host_component.sv */
// Summary of operation
// R1 - divide system clock to pace serial logic
// R2 - drive divided clock out, nominal 12 MHz
// R3 - reset clears everything asynchronously; here sync and done reset high and the control byte loads CTRL_BYTE
// R4 - two sample words, one line each
// R5 - sixteen-bit frame: control plus sample
// R6 - sync low during frame, rising-edge sampling
// R7 - raise sync right after last bit
// R8 - samples go to first channel each
// R9 - three states: idle, shifting, sync-latch
// R10 - idle keeps reloading data and control
// R11 - done high when request acceptable
// R12 - done reports a finished transfer
// R13 - start in idle enters shifting next
// R14 - msb first, counter spans sixteen periods
// R15 - count fifteen moves to sync-latch
// R16 - leave sync-latch only when start low
// R17 - reset forces idle from any state
// R18 - shared clock and sync for both
// R19 - control byte first, held as parameter; here a register writable at CMD_OFFS, with CTRL_BYTE only its reset value
// R20 - data changes on falling serial edge
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps

module ddss_dac_host_component
   import ddss_pkg::*;
#(
   parameter logic [7:0] CTRL_BYTE = CTRL_BYTE_RST, // reset value of the writable control byte
   parameter int         HALF      = SCLK_HALF_CYC  // system cycles per serial half period
)(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire ddss_ahb_in_type   ahb_in,
   output ddss_ahb_out_type       ahb_out,
   output ddss_dac_link_type      dac_link,
   output logic                   done
);

   // state of the block except the reset pipe and the cycle counter
   typedef struct packed {
      ddss_state_type   state;        // control state
      logic [DIV_W-1:0] div;          // serial clock divider
      logic             sclk;         // divided clock level
      logic [3:0]       bit_cnt;      // bits already sent
      logic [15:0]      shift_a;      // frame for converter a
      logic [15:0]      shift_b;      // frame for converter b
      logic [7:0]       hold_a;       // sample a holding register
      logic [7:0]       hold_b;       // sample b holding register
      logic [7:0]       hold_ctrl;    // control byte holding register
      logic             frame_sync_n; // latch line
      logic             done;         // completion flag
      logic             start;        // software start level
      logic [7:0]       word_a;       // software sample a
      logic [7:0]       word_b;       // software sample b
      logic [7:0]       ctrl_byte;    // software control byte
      logic             ap_write;     // write data phase pending
      logic [ADDR_W-1:0] ap_addr;     // address of pending write
      logic [31:0]      rdata;        // read data for data phase
   } ddss_regs_type;

   ddss_regs_type r;            // registered state
   ddss_regs_type next_r;       // next state
   logic          tick;         // divider terminal count
   logic          addr_phase;   // valid address phase this cycle
   logic [1:0]    rst_pipe;     // reset release stages
   logic          rst_sync_n;   // synchronised reset

   // release reset through two flops, assert it at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'b00; // R3
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end

   assign rst_sync_n = rst_pipe[1];

   // register read decode, unmapped reads give zero
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr,
                                             input ddss_regs_type     s);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (addr == CTRL_OFFS) begin
         w[START_BIT] = s.start;
      end else if (addr == SAMPLE_OFFS) begin
         w[WORD_A_LSB +: 8] = s.word_a;
         w[WORD_B_LSB +: 8] = s.word_b;
      end else if (addr == CMD_OFFS) begin
         w[7:0] = s.ctrl_byte;
      end else if (addr == STAT_OFFS) begin
         w[STAT_DONE]       = s.done;
         w[STAT_STATE +: 2] = s.state;
      end
      return w;
   endfunction

   // next-state logic for divider, frame machine and register slave
   always_comb begin
      next_r     = r;
      tick       = (r.div == DIV_W'(HALF - 1));
      addr_phase = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

      // free divider; serial clock toggles each half period
      if (tick) begin
         next_r.div  = '0; // R1
         next_r.sclk = ~r.sclk; // R2
      end else begin
         next_r.div = r.div + DIV_W'(1);
      end

      case (r.state) // R9
         // idle: track inputs, wait for start
         IDLE: begin
            next_r.hold_a       = r.word_a; // R10
            next_r.hold_b       = r.word_b;
            next_r.hold_ctrl    = r.ctrl_byte; // R8
            next_r.frame_sync_n = 1'b1;
            if (r.start) begin
               next_r.state        = SHIFTING; // R13
               next_r.shift_a      = {r.hold_ctrl, r.hold_a}; // R19
               next_r.shift_b      = {r.hold_ctrl, r.hold_b}; // R4
               next_r.bit_cnt      = FIRST_BIT;
               // restart divider so the first bit gets a full low half
               next_r.div          = '0;
               next_r.sclk         = 1'b0;
               next_r.frame_sync_n = 1'b0; // R6
            end
         end
         // shifting: advance on each falling serial edge
         SHIFTING: begin
            if (tick && r.sclk) begin
               if (r.bit_cnt == LAST_BIT) begin
                  next_r.state        = SYNC_LATCH; // R15
                  next_r.frame_sync_n = 1'b1; // R7
               end else begin
                  next_r.bit_cnt = r.bit_cnt + 4'h1; // R14
                  next_r.shift_a = {r.shift_a[14:0], 1'b0}; // R20
                  next_r.shift_b = {r.shift_b[14:0], 1'b0};
               end
            end
         end
         // sync-latch: hold line high until start drops
         SYNC_LATCH: begin
            next_r.frame_sync_n = 1'b1;
            if (!r.start) begin
               next_r.state = IDLE; // R16
            end
         end
         default: begin
            next_r.state = IDLE;
         end
      endcase

      // done follows the state being entered, so it is a clean flop
      next_r.done = (next_r.state != SHIFTING); // R11

      // data phase of a write lands here
      if (r.ap_write) begin
         if (r.ap_addr == CTRL_OFFS) begin
            next_r.start = ahb_in.hwdata[START_BIT];
         end else if (r.ap_addr == SAMPLE_OFFS) begin
            next_r.word_a = ahb_in.hwdata[WORD_A_LSB +: 8];
            next_r.word_b = ahb_in.hwdata[WORD_B_LSB +: 8];
         end else if (r.ap_addr == CMD_OFFS) begin
            next_r.ctrl_byte = ahb_in.hwdata[7:0];
         end
      end

      // address phase: capture write, prepare read data
      next_r.ap_write = addr_phase && ahb_in.hwrite;
      next_r.ap_addr  = ahb_in.haddr[ADDR_W-1:0];
      if (addr_phase && !ahb_in.hwrite) begin
         next_r.rdata = read_word(ahb_in.haddr[ADDR_W-1:0], r);
      end else begin
         next_r.rdata = 32'h0000_0000;
      end
   end

   // single state register
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         r              <= '0; // R17
         r.state        <= IDLE;
         r.frame_sync_n <= FSYNC_RST;
         r.done         <= DONE_RST;
         r.start        <= START_RST;
         r.word_a       <= WORD_RST;
         r.word_b       <= WORD_RST;
         r.ctrl_byte    <= CTRL_BYTE;
      end else begin
         r <= next_r;
      end
   end

   // one clock and one sync serve both converters
   assign dac_link.sclk         = r.sclk; // R18
   assign dac_link.frame_sync_n = r.frame_sync_n;
   assign dac_link.data_a       = r.shift_a[15]; // R5
   assign dac_link.data_b       = r.shift_b[15];
   assign done                  = r.done; // R12

   // zero-wait slave, always okay
   assign ahb_out.hrdata    = r.rdata;
   assign ahb_out.hreadyout = 1'b1;
   assign ahb_out.hresp     = 1'b0;

   // cycles spent in the shifting state, checked at exit
   logic [9:0] shift_cycles;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         shift_cycles <= 10'h000;
      end else if (r.state == SHIFTING) begin
         shift_cycles <= shift_cycles + 10'h001;
      end else begin
         shift_cycles <= 10'h000;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (!rst_sync_n);

   // request seen in idle
   sequence s_frame_start;
      r.state == IDLE && r.start;
   endsequence

   // falling serial edge inside a frame
   sequence s_falling;
      r.state == SHIFTING && tick && r.sclk;
   endsequence

   a_start_shift: assert property ( // R13
      s_frame_start |=> r.state == SHIFTING && !dac_link.frame_sync_n)
      else $error("start in idle did not enter shifting");

   a_sync_low: assert property ( // R6
      r.state == SHIFTING |-> !dac_link.frame_sync_n)
      else $error("frame sync high during shifting");

   a_last_bit: assert property ( // R15
      s_falling ##0 (r.bit_cnt == LAST_BIT)
      |=> r.state == SYNC_LATCH && dac_link.frame_sync_n)
      else $error("last bit did not lead to sync latch");

   a_frame_length: assert property ( // R14
      r.state == SHIFTING && next_r.state == SYNC_LATCH
      |-> shift_cycles == 10'(FRAME_BITS * 2 * HALF - 1))
      else $error("frame length wrong");

   a_return_idle: assert property ( // R16
      r.state == SYNC_LATCH && !r.start |=> r.state == IDLE)
      else $error("sync latch did not return to idle");

   a_hold_sync: assert property ( // R7
      r.state == SYNC_LATCH && r.start
      |=> r.state == SYNC_LATCH && dac_link.frame_sync_n)
      else $error("sync latch left while start high");

   a_done_busy: assert property ( // R12
      r.state == SHIFTING |-> !done)
      else $error("done high during transfer");

   a_done_idle: assert property ( // R11
      r.state == IDLE |-> done)
      else $error("done low while idle");

   a_msb_first: assert property ( // R19
      s_frame_start |=> dac_link.data_a == $past(r.hold_ctrl[7])
                        && dac_link.data_b == $past(r.hold_ctrl[7]))
      else $error("frame does not open with control msb");

   a_bit_stable: assert property ( // R20
      r.state == SHIFTING && $rose(dac_link.sclk)
      |-> $stable(dac_link.data_a) && $stable(dac_link.data_b))
      else $error("data changed at rising serial edge");

   a_sclk_high: assert property ( // R2
      r.state == SHIFTING && $rose(dac_link.sclk)
      |-> dac_link.sclk [*4] ##1 !dac_link.sclk)
      else $error("serial clock high phase wrong");

   a_idle_reload: assert property ( // R10
      r.state == IDLE |=> r.hold_a == $past(r.word_a)
                          && r.hold_ctrl == $past(r.ctrl_byte))
      else $error("holding registers not reloaded in idle");

endmodule

/* verification/ddss_dac_model.sv */
`timescale 1ns/10ps
// behavioural pair of converters on the shared link
module ddss_dac_model
   import ddss_pkg::*;
(
   input  wire ddss_dac_link_type link,
   output logic [15:0]            word_a,
   output logic [15:0]            word_b,
   output int                     nbits
);
   logic [15:0] sh_a = 16'h0000; // shift register, converter a
   logic [15:0] sh_b = 16'h0000; // shift register, converter b
   int          cnt  = 0;        // bits taken this frame

   // take a bit per rising clock, only while selected
   always @(posedge link.sclk) begin
      if (link.frame_sync_n == 1'b0) begin
         sh_a <= {sh_a[14:0], link.data_a};
         sh_b <= {sh_b[14:0], link.data_b};
         cnt  <= cnt + 1;
      end
   end

   // latch on sync rise; a cut frame latches too, like the real part
   always @(posedge link.frame_sync_n) begin
      word_a <= sh_a;
      word_b <= sh_b;
      nbits  <= cnt;
      cnt    <= 0;
   end
endmodule

/* verification/ddss_dac_host_component_tb.sv */
`timescale 1ns/10ps
// self-checking bench for the dual converter shifter
module ddss_dac_host_component_tb
   import ddss_pkg::*;
;
   logic              sys_clk;        // system clock
   logic              rst_n;          // reset, active low
   logic              m_sel;          // master select
   logic [11:0]       m_addr;         // master byte address
   logic [1:0]        m_trans;        // master transfer kind
   logic              m_write;        // master direction
   logic [31:0]       m_wdata;        // master write data
   logic [31:0]       rd;             // last read data
   ddss_ahb_in_type   ahb_in;         // bus request
   ddss_ahb_out_type  ahb_out;        // bus answer
   ddss_dac_link_type dac_link;       // converter lines
   logic              done;           // completion flag
   logic [15:0]       wa;             // frame latched by converter a
   logic [15:0]       wb;             // frame latched by converter b
   int                nbits;          // bits seen in last frame
   int                n_mismatch = 0; // failed comparisons
   int                checks     = 0; // comparisons made

   // word transfers only; hready loops back from the one slave
   assign ahb_in = {m_sel, 20'h00000, m_addr, m_trans, m_write, 3'h2, m_wdata,
                    ahb_out.hreadyout};

   ddss_dac_host_component dut (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .ahb_in   (ahb_in),
      .ahb_out  (ahb_out),
      .dac_link (dac_link),
      .done     (done)
   );

   ddss_dac_model partner (
      .link   (dac_link),
      .word_a (wa),
      .word_b (wb),
      .nbits  (nbits)
   );

   // 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // verdict and end of run
   task conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one comparison of a word
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // edges until hready is seen high; only the watchdog ends a hang
   task edge_rdy;
      do begin
         @(posedge sys_clk);
      end while (ahb_out.hreadyout !== 1'b1);
   endtask

   // one single transfer; read data taken at the closing edge
   task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      m_sel   <= 1'b1;
      m_trans <= 2'h2;
      m_write <= wr;
      m_addr  <= a;
      edge_rdy;
      m_sel   <= 1'b0;
      m_trans <= 2'h0;
      m_wdata <= wd;
      edge_rdy;
      rd = ahb_out.hrdata;
   endtask

   task rdchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   // wait for the completion flag to reach a level, bounded
   task wait_done(input logic v);
      int n;
      n = 0;
      while (done !== v && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      chk({31'h0, done}, {31'h0, v});
   endtask

   // values after reset, unmapped place
   task t_reset;
      chk({30'h0, dac_link.frame_sync_n, done}, 32'h3);
      chk({30'h0, ahb_out.hreadyout, ahb_out.hresp}, 32'h2);
      rdchk(CTRL_OFFS, 32'h0);
      rdchk(SAMPLE_OFFS, 32'h0);
      rdchk(CMD_OFFS, {24'h0, CTRL_BYTE_RST});
      rdchk(STAT_OFFS, 32'h1);
      bus(1'b1, 12'h010, 32'hFFFFFFFF);
      rdchk(12'h010, 32'h0);
   endtask

   // full frame; sample rewritten mid-frame must not leak in
   task t_frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] cb);
      time t0;
      bus(1'b1, CMD_OFFS, {24'h0, cb});
      bus(1'b1, SAMPLE_OFFS, {16'h0, b, a});
      bus(1'b1, CTRL_OFFS, 32'h1);
      wait_done(1'b0);
      chk({31'h0, dac_link.frame_sync_n}, 32'h0);
      @(posedge dac_link.sclk);
      t0 = $time;
      @(posedge dac_link.sclk);
      chk(32'(($time - t0) / 10), 32'(2 * SCLK_HALF_CYC));
      rdchk(STAT_OFFS, 32'h2);
      bus(1'b1, SAMPLE_OFFS, {16'h0, ~b, ~a});
      wait_done(1'b1);
      chk({16'h0, wa}, {16'h0, cb, a});
      chk({16'h0, wb}, {16'h0, cb, b});
      chk(32'(nbits), 32'h10);
      repeat (10) @(posedge sys_clk);
      rdchk(STAT_OFFS, 32'h5);
      bus(1'b1, CTRL_OFFS, 32'h0);
      repeat (2) @(posedge sys_clk);
      rdchk(STAT_OFFS, 32'h1);
   endtask

   // reset cut into a running frame; it must act before the next edge
   task t_abort;
      bus(1'b1, CTRL_OFFS, 32'h1);
      wait_done(1'b0);
      repeat (40) @(posedge sys_clk);
      rst_n <= 1'b0;
      #1 chk({30'h0, dac_link.frame_sync_n, done}, 32'h3);
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      rdchk(STAT_OFFS, 32'h1);
      rdchk(CTRL_OFFS, 32'h0);
   endtask

   // main sequence
   initial begin
      rst_n   = 1'b0;
      m_sel   = 1'b0;
      m_addr  = 12'h000;
      m_trans = 2'h0;
      m_write = 1'b0;
      m_wdata = 32'h0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_reset;
      t_frame(8'hA5, 8'h3C, CTRL_BYTE_RST);
      t_frame(8'h00, 8'hFF, 8'h81);
      t_abort;
      conclude;
   end

   // hang guard, far beyond the expected run
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      conclude;
   end
endmodule
